// *** rtl/recorder_output_setting_commands.sv ***
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "recorder_consts.svh"

module recorder_output_setting_commands (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic DOT_MODEL,
    input wire logic PAPER_WIDE,
    input wire logic ETH_CONNECTED,
    input wire logic LINK_ETH,
    input wire logic [63:0] STATUS_IN,
    input wire logic [31:0] DATA_IN,
    input wire logic DATA_BINARY,
    output logic BYTE_ORDER,
    output logic CHECKSUM_EN,
    output logic ADJ_ACTIVE,
    output logic CMD_ERR,
    output logic [1:0] MODE,
    output logic [1:0] ADJ_SEL,
    output logic [2:0] ADJ_PEN,
    output logic [8:0] ADJ_VALUE,
    output logic [63:0] STATUS_OUT,
    output logic [31:0] DATA_OUT
);

    // ==========================================
    // pin synchronisers
    logic dot_s1;
    logic dot_s2;
    logic wide_s1;
    logic wide_s2;
    logic eth_s1;
    logic eth_s2;
    logic eth_s3;
    logic eth_fall;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            dot_s1 <= 1'b0;
            dot_s2 <= 1'b0;
            wide_s1 <= 1'b0;
            wide_s2 <= 1'b0;
            eth_s1 <= 1'b0;
            eth_s2 <= 1'b0;
            eth_s3 <= 1'b0;
        end else begin
            dot_s1 <= DOT_MODEL;
            dot_s2 <= dot_s1;
            wide_s1 <= PAPER_WIDE;
            wide_s2 <= wide_s1;
            eth_s1 <= ETH_CONNECTED;
            eth_s2 <= eth_s1;
            eth_s3 <= eth_s2;
        end
    end

    assign eth_fall = eth_s3 & ~eth_s2;

    // ==========================================
    // parameter range check
    function automatic logic val_ok(
        input logic dot,
        input logic wide,
        input logic [1:0] sel,
        input logic signed [8:0] v
    );
        int x;
        int lo;
        int hi;
        x = int'(v);
        lo = 0;
        hi = -1;
        if (!dot) begin
            case (sel)
                recorder_pkg::SEL_ZERO: begin
                    hi = wide ? `PEN_ZERO_W : `PEN_ZERO_N;
                end
                recorder_pkg::SEL_SPAN: begin
                    hi = wide ? `PEN_SPAN_W : `PEN_SPAN_N;
                    lo = -hi;
                end
                default: begin
                    hi = -1;
                end
            endcase
        end else begin
            case (sel)
                recorder_pkg::SEL_ZERO: begin
                    hi = wide ? `DOT_ZERO_W : `DOT_ZERO_N;
                end
                recorder_pkg::SEL_SPAN: begin
                    hi = wide ? `DOT_SPAN_W : `DOT_SPAN_N;
                    lo = -hi;
                end
                recorder_pkg::SEL_HYST: begin
                    hi = `DOT_HYST;
                    lo = -hi;
                end
                default: begin
                    hi = -1;
                end
            endcase
        end
        return (x >= lo) && (x <= hi);
    endfunction : val_ok

    // ==========================================
    // command state
    recorder_pkg::adj_state_t adj;
    recorder_pkg::adj_state_t next_adj;
    logic bord;
    logic next_bord;
    logic csum;
    logic next_csum;
    logic err;
    logic next_err;
    logic [1:0] mode;
    logic [1:0] next_mode;
    logic [1:0] sel;
    logic [1:0] next_sel;
    logic [2:0] pen;
    logic [2:0] next_pen;
    logic [8:0] val;
    logic [8:0] next_val;
    logic [31:0] flt_lo;
    logic [31:0] next_flt_lo;
    logic [31:0] flt_hi;
    logic [31:0] next_flt_hi;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [63:0] stat;
    logic [63:0] next_stat;
    logic [31:0] dout;
    logic [31:0] next_dout;

    logic [1:0] w_sel;
    logic [2:0] w_pen;
    logic [8:0] w_val;
    logic set_err;

    assign w_sel = WDATA[`SEL_MSB:`SEL_LSB];
    assign w_pen = WDATA[`PEN_MSB:`PEN_LSB];
    assign w_val = WDATA[`VAL_MSB:0];

    always_comb begin
        next_adj = adj;
        next_bord = bord;
        next_csum = csum;
        next_mode = mode;
        next_sel = sel;
        next_pen = pen;
        next_val = val;
        next_flt_lo = flt_lo;
        next_flt_hi = flt_hi;
        next_rdata = 32'h0;
        set_err = 1'b0;
        if (WR) begin
            if (ADDR == `A_STOP) begin
                if (WDATA == 32'h0) begin
                    next_adj = recorder_pkg::ADJ_IDLE;
                end else begin
                    set_err = 1'b1;
                end
            end else if (ADDR == `A_PEN) begin
                // pen numbers outside 1..4 and dot units refuse it
                if (!dot_s2 && w_pen >= 3'(`PEN_MIN) && w_pen <= 3'(`PEN_MAX)
                    && val_ok(1'b0, wide_s2, w_sel, w_val)) begin
                    next_adj = recorder_pkg::ADJ_RUN;
                    next_sel = w_sel;
                    next_pen = w_pen;
                    next_val = w_val;
                end else begin
                    set_err = 1'b1;
                end
            end else if (ADDR == `A_DOT) begin
                if (dot_s2 && val_ok(1'b1, wide_s2, w_sel, w_val)) begin
                    next_adj = recorder_pkg::ADJ_RUN;
                    next_sel = w_sel;
                    next_pen = 3'h0;
                    next_val = w_val;
                end else begin
                    set_err = 1'b1;
                end
            end else if (ADDR == `A_BORD) begin
                if (WDATA[31:1] == 31'h0) begin
                    next_bord = WDATA[0];
                end else begin
                    set_err = 1'b1;
                end
            end else if (ADDR == `A_CSUM) begin
                if (WDATA[31:1] == 31'h0 && !LINK_ETH) begin
                    next_csum = WDATA[0];
                end else begin
                    set_err = 1'b1;
                end
            end else if (ADDR == `A_FLT_LO) begin
                // a lone low write leaves the upper mask as it was
                next_flt_lo = WDATA;
            end else if (ADDR == `A_FLT_HI) begin
                next_flt_hi = WDATA;
            end else if (ADDR == `A_MODE) begin
                if (adj == recorder_pkg::ADJ_RUN) begin
                    set_err = 1'b1;
                end else begin
                    next_mode = WDATA[1:0];
                end
            end else if (ADDR == `A_EXIT) begin
                next_bord = `BORD_DEF;
                next_csum = `CSUM_DEF;
                next_flt_lo = `FLT_DEF;
                next_flt_hi = `FLT_DEF;
            end else begin
                set_err = 1'b1;
            end
        end
        if (eth_fall) begin
            next_bord = `BORD_DEF;
            next_flt_lo = `FLT_DEF;
            next_flt_hi = `FLT_DEF;
        end
        if (RD) begin
            if (ADDR == `A_STOP) begin
                next_rdata = {31'h0, adj};
            end else if (ADDR == `A_PEN || ADDR == `A_DOT) begin
                next_rdata = {14'h0, sel, 1'b0, pen, 3'h0, val};
            end else if (ADDR == `A_BORD) begin
                next_rdata = {31'h0, bord};
            end else if (ADDR == `A_CSUM) begin
                next_rdata = {31'h0, csum};
            end else if (ADDR == `A_FLT_LO) begin
                next_rdata = flt_lo;
            end else if (ADDR == `A_FLT_HI) begin
                next_rdata = flt_hi;
            end else if (ADDR == `A_MODE) begin
                next_rdata = {30'h0, mode};
            end else if (ADDR == `A_STAT) begin
                next_rdata = {27'h0, wide_s2, dot_s2, eth_s2, adj, err};
            end else begin
                next_rdata = 32'h0;
            end
        end
        // reading status clears the error, a new error wins
        next_err = (err & ~(RD && ADDR == `A_STAT)) | set_err;
        next_stat = STATUS_IN & {flt_hi, flt_lo};
        if (DATA_BINARY && bord) begin
            next_dout = {DATA_IN[7:0], DATA_IN[15:8], DATA_IN[23:16], DATA_IN[31:24]};
        end else begin
            next_dout = DATA_IN;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            adj <= recorder_pkg::ADJ_IDLE;
            bord <= `BORD_DEF;
            csum <= `CSUM_DEF;
            err <= 1'b0;
            mode <= 2'h0;
            sel <= 2'h0;
            pen <= 3'h0;
            val <= 9'h000;
            flt_lo <= `FLT_DEF;
            flt_hi <= `FLT_DEF;
            rdata <= 32'h0;
            stat <= 64'h0;
            dout <= 32'h0;
        end else begin
            adj <= next_adj;
            bord <= next_bord;
            csum <= next_csum;
            err <= next_err;
            mode <= next_mode;
            sel <= next_sel;
            pen <= next_pen;
            val <= next_val;
            flt_lo <= next_flt_lo;
            flt_hi <= next_flt_hi;
            rdata <= next_rdata;
            stat <= next_stat;
            dout <= next_dout;
        end
    end

    assign RDATA = rdata;
    assign BYTE_ORDER = bord;
    assign CHECKSUM_EN = csum;
    assign ADJ_ACTIVE = adj;
    assign CMD_ERR = err;
    assign MODE = mode;
    assign ADJ_SEL = sel;
    assign ADJ_PEN = pen;
    assign ADJ_VALUE = val;
    assign STATUS_OUT = stat;
    assign DATA_OUT = dout;

    // ==========================================
    // checks
    a_stop_ends:
    assert property (@(posedge CLK) disable iff (!RST_N)
        WR && ADDR == `A_STOP && WDATA == 32'h0 |=> !ADJ_ACTIVE)
        else $error("stop did not end adjustment");

    a_stop_bad:
    assert property (@(posedge CLK) disable iff (!RST_N)
        WR && ADDR == `A_STOP && WDATA != 32'h0 |=> CMD_ERR && $stable(ADJ_ACTIVE))
        else $error("bad stop parameter accepted");

    a_query_state:
    assert property (@(posedge CLK) disable iff (!RST_N)
        RD && ADDR == `A_STOP |=> RDATA == {31'h0, $past(ADJ_ACTIVE)})
        else $error("adjust state read wrong");

    a_pen_index:
    assert property (@(posedge CLK) disable iff (!RST_N)
        WR && ADDR == `A_PEN && (w_pen == 3'h0 || w_pen > 3'h4) |=> CMD_ERR && $stable(ADJ_PEN))
        else $error("pen index out of range accepted");

    a_mode_lock:
    assert property (@(posedge CLK) disable iff (!RST_N)
        WR && ADDR == `A_MODE && ADJ_ACTIVE |=> $stable(MODE) && CMD_ERR)
        else $error("mode changed during adjustment");

    a_order_swap:
    assert property (@(posedge CLK) disable iff (!RST_N)
        DATA_BINARY && BYTE_ORDER |=> DATA_OUT[7:0] == $past(DATA_IN[31:24]))
        else $error("binary data not swapped");

    a_ascii_pass:
    assert property (@(posedge CLK) disable iff (!RST_N)
        !DATA_BINARY |=> DATA_OUT == $past(DATA_IN))
        else $error("ascii data altered");

    a_csum_eth:
    assert property (@(posedge CLK) disable iff (!RST_N)
        WR && ADDR == `A_CSUM && LINK_ETH |=> $stable(CHECKSUM_EN) && CMD_ERR)
        else $error("checksum set over ethernet");

    a_eth_drop:
    assert property (@(posedge CLK) disable iff (!RST_N)
        eth_fall |=> !BYTE_ORDER && flt_lo == `FLT_DEF && flt_hi == `FLT_DEF)
        else $error("settings kept after link drop");

    a_exit_dflt:
    assert property (@(posedge CLK) disable iff (!RST_N)
        WR && ADDR == `A_EXIT |=> !BYTE_ORDER && !CHECKSUM_EN && flt_lo == `FLT_DEF && flt_hi == `FLT_DEF)
        else $error("basic-mode exit kept settings");

endmodule : recorder_output_setting_commands

`default_nettype wire

// *** rtl/recorder_consts.svh ***
`ifndef RECORDER_CONSTS_SVH
`define RECORDER_CONSTS_SVH
// ==========================================
// register map, byte addresses
`define A_STOP 8'h00
`define A_PEN 8'h04
`define A_DOT 8'h08
`define A_BORD 8'h0c
`define A_CSUM 8'h10
`define A_FLT_LO 8'h14
`define A_FLT_HI 8'h18
`define A_MODE 8'h1c
`define A_STAT 8'h20
`define A_EXIT 8'h24
// ==========================================
// adjust command fields
`define VAL_MSB 8
`define PEN_LSB 12
`define PEN_MSB 14
`define SEL_LSB 16
`define SEL_MSB 17
`define PEN_MIN 1
`define PEN_MAX 4
// ==========================================
// limits, 1/30 mm for pens, dots for dot units
`define PEN_ZERO_N 70
`define PEN_ZERO_W 180
`define PEN_SPAN_N 45
`define PEN_SPAN_W 165
`define DOT_HYST 7
`define DOT_ZERO_N 15
`define DOT_ZERO_W 50
`define DOT_SPAN_N 30
`define DOT_SPAN_W 50
// ==========================================
// defaults
`define BORD_DEF 1'b0
`define CSUM_DEF 1'b0
`define FLT_DEF 32'hffffffff
`endif

// *** rtl/recorder_pkg.sv ***
package recorder_pkg;
    typedef enum logic {
        ADJ_IDLE = 1'b0,
        ADJ_RUN = 1'b1
    } adj_state_t;
    typedef enum logic [1:0] {
        SEL_ZERO = 2'b00,
        SEL_SPAN = 2'b01,
        SEL_HYST = 2'b10,
        SEL_BAD = 2'b11
    } adj_sel_t;
endpackage : recorder_pkg

// *** sim/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host side of the register port
module host_model (
    input wire logic clk,
    output logic [7:0] addr,
    output logic [31:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        addr = 8'h00;
        wdata = 32'h00000000;
        wr = 1'b0;
        rd = 1'b0;
    end

    // one-cycle strobe; lines are scrambled after release so stale values never look valid
    task access(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask : access
endmodule : host_model
`default_nettype wire

// *** sim/tb_recorder_output_setting_commands.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "recorder_consts.svh"
module tb_recorder_output_setting_commands;
    logic CLK, RST_N, WR, RD, DOT_MODEL, PAPER_WIDE, ETH_CONNECTED, LINK_ETH, DATA_BINARY;
    logic BYTE_ORDER, CHECKSUM_EN, ADJ_ACTIVE, CMD_ERR, rd_seen;
    logic [7:0] ADDR;
    logic [31:0] WDATA, RDATA, DATA_IN, DATA_OUT, w, lo, hi;
    logic [63:0] STATUS_IN, STATUS_OUT;
    logic [1:0] MODE, ADJ_SEL;
    logic [2:0] ADJ_PEN;
    logic [8:0] ADJ_VALUE;
    logic [31:0] rq[$];
    int failures = 0;
    int checks_done = 0;
    int tc[23][7] = '{'{4,0,0,0,1,70,1}, '{4,0,0,0,1,71,0}, '{4,0,1,0,4,180,1}, '{4,0,1,0,4,181,0},
        '{4,0,0,1,2,-45,1}, '{4,0,0,1,2,-46,0}, '{4,0,1,1,3,165,1}, '{4,0,1,1,3,-166,0},
        '{4,0,0,0,0,0,0}, '{4,0,0,0,5,0,0}, '{4,0,0,2,1,0,0}, '{8,0,0,0,0,0,0},
        '{8,1,0,2,0,-7,1}, '{8,1,1,2,0,8,0}, '{8,1,0,0,0,15,1}, '{8,1,0,0,0,16,0},
        '{8,1,1,0,0,50,1}, '{8,1,0,1,0,-30,1}, '{8,1,0,1,0,31,0}, '{8,1,1,1,0,-50,1},
        '{8,1,1,1,0,51,0}, '{8,1,0,3,0,0,0}, '{4,1,0,0,1,0,0}};

    recorder_output_setting_commands DUT (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .DOT_MODEL(DOT_MODEL), .PAPER_WIDE(PAPER_WIDE),
        .ETH_CONNECTED(ETH_CONNECTED), .LINK_ETH(LINK_ETH), .STATUS_IN(STATUS_IN), .DATA_IN(DATA_IN),
        .DATA_BINARY(DATA_BINARY), .BYTE_ORDER(BYTE_ORDER), .CHECKSUM_EN(CHECKSUM_EN),
        .ADJ_ACTIVE(ADJ_ACTIVE), .CMD_ERR(CMD_ERR), .MODE(MODE), .ADJ_SEL(ADJ_SEL), .ADJ_PEN(ADJ_PEN),
        .ADJ_VALUE(ADJ_VALUE), .STATUS_OUT(STATUS_OUT), .DATA_OUT(DATA_OUT));
    host_model u_host (.clk(CLK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD));

    // ==========================================
    // helpers
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task step(input int n);
        repeat (n) @(negedge CLK);
    endtask : step

    task wr(input logic [7:0] a, input logic [31:0] d);
        u_host.access(1'b1, a, d);
        step(1);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        u_host.access(1'b0, a, 32'h00000000);
    endtask : rd

    // fresh random status and data; registered outputs settle one edge later
    task drive(input logic bin);
        @(posedge CLK);
        STATUS_IN <= {$urandom, $urandom};
        DATA_IN <= $urandom;
        DATA_BINARY <= bin;
        step(2);
    endtask : drive

    function automatic logic [31:0] swap(input logic [31:0] d);
        return {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction : swap

    function automatic logic [31:0] stat(input logic adj, input logic err);
        return {27'h0000000, PAPER_WIDE, DOT_MODEL, 1'b1, adj, err};
    endfunction : stat

    task test_done;
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // read data stands only in the cycle after the strobe
    always @(posedge CLK) begin
        if (rd_seen) begin
            chk(RDATA, rq.pop_front());
        end
        rd_seen <= RD;
    end

    initial begin
        repeat (6000) @(posedge CLK);
        failures++;
        test_done();
    end

    // ==========================================
    // main sequence
    initial begin
        RST_N = 1'b0;
        DOT_MODEL = 1'b0;
        PAPER_WIDE = 1'b0;
        ETH_CONNECTED = 1'b1;
        LINK_ETH = 1'b0;
        DATA_BINARY = 1'b1;
        STATUS_IN = 64'h0000000000000000;
        DATA_IN = 32'h00000000;
        rd_seen = 1'b0;
        void'($urandom(32'hde46));
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        drive(1'b1);
        chk(BYTE_ORDER, 1'b0);
        chk(CHECKSUM_EN, 1'b0);
        chk(STATUS_OUT, STATUS_IN);
        chk(DATA_OUT, DATA_IN);
        wr(`A_BORD, 32'h00000001);
        chk(BYTE_ORDER, 1'b1);
        // data register needs one more edge to see the new order
        step(1);
        chk(DATA_OUT, swap(DATA_IN));
        drive(1'b0);
        chk(DATA_OUT, DATA_IN);
        wr(`A_BORD, 32'h00000002);
        chk(BYTE_ORDER, 1'b1);
        chk(CMD_ERR, 1'b1);
        rd(`A_STAT, stat(1'b0, 1'b1));
        wr(`A_CSUM, 32'h00000001);
        chk(CHECKSUM_EN, 1'b1);
        @(posedge CLK) LINK_ETH <= 1'b1;
        wr(`A_CSUM, 32'h00000000);
        chk(CHECKSUM_EN, 1'b1);
        chk(CMD_ERR, 1'b1);
        @(posedge CLK) LINK_ETH <= 1'b0;
        rd(`A_STAT, stat(1'b0, 1'b1));
        lo = $urandom;
        hi = $urandom;
        wr(`A_FLT_LO, lo);
        wr(`A_FLT_HI, hi);
        drive(1'b1);
        chk(STATUS_OUT, STATUS_IN & {hi, lo});
        wr(`A_EXIT, 32'h00000000);
        chk(BYTE_ORDER, 1'b0);
        chk(CHECKSUM_EN, 1'b0);
        drive(1'b1);
        chk(STATUS_OUT, STATUS_IN);
        wr(`A_BORD, 32'h00000001);
        wr(`A_CSUM, 32'h00000001);
        wr(`A_FLT_HI, hi);
        @(posedge CLK) ETH_CONNECTED <= 1'b0;
        step(8);
        chk(BYTE_ORDER, 1'b0);
        chk(CHECKSUM_EN, 1'b1);
        drive(1'b1);
        chk(STATUS_OUT, STATUS_IN);
        @(posedge CLK) ETH_CONNECTED <= 1'b1;
        // straps pass a two-stage synchroniser, hence the wait
        for (int i = 0; i < 23; i++) begin
            @(posedge CLK);
            DOT_MODEL <= tc[i][1][0];
            PAPER_WIDE <= tc[i][2][0];
            step(5);
            w = (tc[i][3] << 16) | (tc[i][4] << 12) | (tc[i][5] & 32'h000001ff);
            wr(tc[i][0][7:0], w);
            chk(ADJ_ACTIVE, tc[i][6][0]);
            chk(CMD_ERR, !tc[i][6][0]);
            rd(`A_STAT, stat(tc[i][6][0], !tc[i][6][0]));
            if (tc[i][6] == 1) begin
                chk(ADJ_VALUE, w[8:0]);
                chk(ADJ_SEL, tc[i][3][1:0]);
                chk(ADJ_PEN, tc[i][4][2:0]);
                wr(`A_MODE, 32'h00000002);
                chk(MODE, 2'h0);
                wr(`A_STOP, 32'h00000001);
                chk(ADJ_ACTIVE, 1'b1);
                rd(`A_STOP, 32'h00000001);
                wr(`A_STOP, 32'h00000000);
                chk(ADJ_ACTIVE, 1'b0);
                rd(`A_STOP, 32'h00000000);
                rd(`A_STAT, stat(1'b0, 1'b1));
            end
        end
        wr(`A_MODE, 32'h00000003);
        chk(MODE, 2'h3);
        step(3);
        test_done();
    end
endmodule : tb_recorder_output_setting_commands
`default_nettype wire
